// File: hdl/dvsd_pkg.sv
package dvsd_pkg;
  // -------------------------------------------------------------
  // Register pages and offsets
  // -------------------------------------------------------------
  localparam logic [7:0] PG_MAIN = 8'h00;
  localparam logic [7:0] PG_COEF = 8'h09;
  localparam logic [6:0] A_FLAG = 7'h26;
  localparam logic [6:0] A_STEP = 7'h3f;
  localparam logic [6:0] A_VCTL = 7'h40;
  localparam logic [6:0] A_GL = 7'h41;
  localparam logic [6:0] A_GR = 7'h42;
  localparam logic [6:0] A_DRC = 7'h44;
  localparam logic [6:0] A_RATE = 7'h46;
  localparam logic [6:0] A_PCTL = 7'h74;
  localparam logic [6:0] A_PGAIN = 7'h75;
  localparam logic [6:0] A_COEF0 = 7'h0e;
  localparam logic [6:0] A_COEF5 = 7'h19;
  // -------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------
  localparam int FLG_L = 4;
  localparam int FLG_R = 0;
  localparam int VC_MUTE_L = 3;
  localparam int VC_MUTE_R = 2;
  localparam int DRC_EN_L = 6;
  localparam int DRC_EN_R = 5;
  localparam int PC_EN = 7;
  localparam int PC_CLK = 6;
  localparam logic [7:0] PCTL_MASK = 8'hc7;
  // -------------------------------------------------------------
  // Modes and states
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    STEP_NORM = 2'b00, STEP_SLOW = 2'b01, STEP_OFF = 2'b10, STEP_OFF2 = 2'b11
  } dvsd_step_t;
  localparam logic [1:0] VM_LEFT = 2'b01;
  localparam logic [1:0] VM_RIGHT = 2'b10;
  typedef enum logic [1:0] {
    DRC_IDLE = 2'b00, DRC_ATTACK = 2'b01, DRC_DECAY = 2'b10
  } dvsd_drc_t;
  // -------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------
  localparam logic [6:0] DRC_RST = 7'h0f;
  // Order: high-pass numerator taps zero and one, denominator tap one, then low-pass alike.
  localparam logic [5:0][15:0] COEF_RST = {16'h7fde, 16'h0011, 16'h0011,
                                           16'h7f56, 16'h8055, 16'h7fab};
  // -------------------------------------------------------------
  // Gain arithmetic, in 0.125 dB units
  // -------------------------------------------------------------
  localparam logic signed [9:0] MUTE_Q = -10'sd512;
  localparam logic signed [10:0] EFF_FLOOR = -11'sd508;
  localparam logic [10:0] Q_OFFSET = 11'd528;
  localparam logic [10:0] STEPS_6DB = 11'd48;
  localparam logic [16:0] FRAC_STEP = 17'd683;
  localparam logic [16:0] UNITY_Q15 = 17'h08000;
  localparam logic [4:0] SH_BASE = 5'd26;
  // Potentiometer code map, 0.5 dB units.
  localparam logic [7:0] POT_TOP = 8'd36;
  localparam logic [7:0] POT_KNEE_BASE = 8'd126;
  localparam logic [6:0] POT_KNEE = 7'd90;
  localparam logic [6:0] POT_MUTE = 7'd127;
  // -------------------------------------------------------------
  // Compressor, attenuation in 2^-20 dB units
  // -------------------------------------------------------------
  localparam logic [7:0][15:0] THR_TAB = {16'h0814, 16'h0b68, 16'h101d, 16'h16c3,
                                          16'h2027, 16'h2d6b, 16'h4027, 16'h5a9d};
  localparam logic [3:0][12:0] HYS_UP = {13'd5786, 13'd5157, 13'd4596, 13'd4096};
  localparam logic [3:0][12:0] HYS_DN = {13'd2900, 13'd3254, 13'd3650, 13'd4096};
  localparam logic [25:0] ATK_BASE = 26'd4194304;
  localparam logic [25:0] DCY_BASE = 26'd1638;
  localparam logic [25:0] ATTEN_MAX = 26'd25165824;
  localparam int ATTEN_FRAC = 17;
  // -------------------------------------------------------------
  // State records
  // -------------------------------------------------------------
  typedef struct packed {
    logic [1:0] step;
    logic [3:0] vctl;
    logic [7:0] gl;
    logic [7:0] gr;
    logic [6:0] drc;
    logic [7:0] rate;
    logic [7:0] pctl;
    logic [6:0] pcode;
    logic [5:0][15:0] coef;
    logic signed [9:0] appl_l;
    logic signed [9:0] appl_r;
    logic half;
    dvsd_drc_t dst;
    logic [25:0] atten;
    logic vvalid;
    logic signed [15:0] vol_l;
    logic signed [15:0] vol_r;
    logic [15:0] energy;
    logic [7:0] rdata;
  } dvsd_state_t;
  typedef struct packed {
    logic signed [15:0] x1;
    logic signed [15:0] y1;
    logic valid;
  } dvsd_iir_t;
  // Clamp a wide signed value to 16 bits.
  function automatic logic signed [15:0] dvsd_sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      return 16'sh7fff;
    end else if (v < -34'sd32768) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction
endpackage

// File: hdl/dvsd_iir1.sv
`timescale 1ns/100ps
`default_nettype none
module dvsd_iir1
  import dvsd_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Sample in
  input wire logic i_valid,
  input wire logic signed [15:0] i_x,
  // Coefficients
  input wire logic signed [15:0] i_numerator_tap_zero,
  input wire logic signed [15:0] i_numerator_tap_one,
  input wire logic signed [15:0] i_denominator_tap_one,
  // Sample out
  output logic o_valid,
  output logic signed [15:0] o_y
);
  dvsd_iir_t s; // Registered filter state.
  dvsd_iir_t n; // Next filter state.
  logic signed [31:0] p0; // Current-sample product.
  logic signed [31:0] p1; // Delayed-sample product.
  logic signed [31:0] p2; // Feedback product.
  logic signed [33:0] acc; // Sum before the 2^15 division.

  // -------------------------------------------------------------
  // One first-order section per sample strobe
  // -------------------------------------------------------------
  // The feedback product is added because the denominator subtracts it.
  always_comb begin
    n = s;
    p0 = i_numerator_tap_zero * i_x;
    p1 = i_numerator_tap_one * s.x1;
    p2 = i_denominator_tap_one * s.y1;
    acc = {{2{p0[31]}}, p0} + {{2{p1[31]}}, p1} + {{2{p2[31]}}, p2};
    n.valid = i_valid;
    if (i_valid) begin
      n.x1 = i_x;
      n.y1 = dvsd_sat16(acc >>> 15);
    end
  end

  // The output is the stored y1, so it is a flop.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_valid = s.valid;
  assign o_y = s.y1;
endmodule
`default_nettype wire

// File: hdl/dvsd_top.sv
`timescale 1ns/100ps
`default_nettype none
module dvsd_top
  import dvsd_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_page,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Playback samples
  input wire logic i_smp_valid,
  input wire logic signed [15:0] i_smp_l,
  input wire logic signed [15:0] i_smp_r,
  output logic o_vol_valid,
  output logic signed [15:0] o_vol_l,
  output logic signed [15:0] o_vol_r,
  output logic o_hpf_valid,
  output logic signed [15:0] o_hpf,
  output logic [15:0] o_energy,
  // Volume potentiometer converter
  input wire logic i_pot_valid,
  input wire logic [6:0] i_pot_code,
  output logic o_pot_clk_sel,
  output logic [2:0] o_pot_rate,
  // Status
  output logic o_step_busy,
  output logic o_drc_active
);
  // -------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------
  logic rst_meta; // First stage, read only by the second.
  logic rst_n_s; // Released reset used everywhere else.

  // Assertion is immediate, release waits two clock edges.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_s <= rst_meta;
    end
  end

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  dvsd_state_t s; // All registered state except the reset-release flops and the two filter sections.
  dvsd_state_t n; // Next state.
  logic [7:0] src_l; // Left gain source after master select.
  logic [7:0] src_r; // Right gain source after master select.
  logic mute_l; // Left mute request.
  logic mute_r; // Right mute request.
  logic signed [9:0] tgt_l; // Left target, 0.125 dB units.
  logic signed [9:0] tgt_r; // Right target, 0.125 dB units.
  logic done_l; // Left applied equals target.
  logic done_r; // Right applied equals target.
  logic signed [10:0] cut; // Compressor cut, 0.125 dB units.
  logic signed [10:0] eff_l; // Left gain after compression.
  logic signed [10:0] eff_r; // Right gain after compression.
  logic step_go; // This sample moves the applied gains.
  logic pot_en; // Pin volume mode.
  logic signed [16:0] mono; // Sum feeding the estimator.
  logic hp_valid; // High-pass output strobe.
  logic signed [15:0] hp_y; // High-pass output.
  logic lp_valid; // Low-pass output strobe.
  logic signed [15:0] lp_y; // Low-pass output.
  logic [28:0] thr_hi; // Rising threshold, Q12.
  logic [28:0] thr_lo; // Falling threshold, Q12.
  logic above; // Energy over the rising threshold.
  logic below; // Energy under the falling threshold.
  logic [7:0] rd_mux; // Read data before the output flop.
  logic [2:0] ci; // Coefficient index of a page-9 access.

  // -------------------------------------------------------------
  // Gain helpers
  // -------------------------------------------------------------
  // Scale by 2^(g/48) with a linear step inside each 6 dB octave;
  // this trades up to 0.5 dB of shape error for no lookup table.
  function automatic logic signed [15:0] apply_gain(input logic signed [15:0] x,
                                                    input logic signed [10:0] g);
    logic [10:0] pos;
    logic [10:0] q;
    logic [10:0] r;
    logic [16:0] m;
    logic signed [33:0] p;
    logic [4:0] sh;
    pos = 11'(g + $signed(Q_OFFSET));
    q = pos / STEPS_6DB;
    r = pos % STEPS_6DB;
    m = UNITY_Q15 + 17'(r) * FRAC_STEP;
    p = x * $signed({1'b0, m});
    sh = SH_BASE - q[4:0];
    if (g < EFF_FLOOR) begin
      return 16'sh0000;
    end
    return dvsd_sat16(p >>> sh);
  endfunction

  // Pot code to half-dB register value, modular in eight bits.
  function automatic logic [7:0] pot_map(input logic [6:0] c);
    if (c <= POT_KNEE) begin
      return POT_TOP - {1'b0, c};
    end
    return POT_KNEE_BASE - {c, 1'b0};
  endfunction

  // -------------------------------------------------------------
  // Targets and completion
  // -------------------------------------------------------------
  assign pot_en = s.pctl[PC_EN];
  // One register can govern both channels.
  assign src_l = (s.vctl[1:0] == VM_RIGHT) ? s.gr : s.gl;
  assign src_r = (s.vctl[1:0] == VM_LEFT) ? s.gl : s.gr;
  // Code 127 mutes without touching the host's gain registers.
  assign mute_l = s.vctl[VC_MUTE_L] | (pot_en && s.pcode == POT_MUTE);
  assign mute_r = s.vctl[VC_MUTE_R] | (pot_en && s.pcode == POT_MUTE);
  assign tgt_l = mute_l ? MUTE_Q : $signed({src_l, 2'b00});
  assign tgt_r = mute_r ? MUTE_Q : $signed({src_r, 2'b00});
  assign done_l = (s.appl_l == tgt_l);
  assign done_r = (s.appl_r == tgt_r);
  // The core clock must keep running while this is high.
  assign o_step_busy = ~(done_l & done_r);
  assign cut = $signed({2'b00, s.atten[ATTEN_FRAC+8:ATTEN_FRAC]});
  assign eff_l = {s.appl_l[9], s.appl_l} - (s.drc[DRC_EN_L] ? cut : 11'sd0);
  assign eff_r = {s.appl_r[9], s.appl_r} - (s.drc[DRC_EN_R] ? cut : 11'sd0);
  // Slow mode moves on every second sample only.
  assign step_go = i_smp_valid && ((s.step == STEP_NORM) ||
                   (s.step == STEP_SLOW && s.half));

  // -------------------------------------------------------------
  // Energy estimator
  // -------------------------------------------------------------
  assign mono = 17'(s.vol_l) + 17'(s.vol_r);

  dvsd_iir1 u_hpf (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n_s),
    .i_valid(s.vvalid),
    .i_x(mono[16:1]),
    .i_numerator_tap_zero(s.coef[0]),
    .i_numerator_tap_one(s.coef[1]),
    .i_denominator_tap_one(s.coef[2]),
    .o_valid(hp_valid),
    .o_y(hp_y)
  );

  dvsd_iir1 u_lpf (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n_s),
    .i_valid(hp_valid),
    .i_x(hp_y),
    .i_numerator_tap_zero(s.coef[3]),
    .i_numerator_tap_one(s.coef[4]),
    .i_denominator_tap_one(s.coef[5]),
    .o_valid(lp_valid),
    .o_y(lp_y)
  );

  // A window around the threshold stops rapid on-off toggling.
  assign thr_hi = THR_TAB[s.drc[4:2]] * HYS_UP[s.drc[1:0]];
  assign thr_lo = THR_TAB[s.drc[4:2]] * HYS_DN[s.drc[1:0]];
  assign above = {1'b0, s.energy, 12'h000} > thr_hi;
  assign below = {1'b0, s.energy, 12'h000} < thr_lo;

  // -------------------------------------------------------------
  // Read multiplexer
  // -------------------------------------------------------------
  // Unmapped offsets read as zero.
  always_comb begin
    rd_mux = 8'h00;
    ci = 3'((i_reg_addr - A_COEF0) >> 1);
    if (i_reg_page == PG_MAIN) begin
      case (i_reg_addr)
        A_FLAG: rd_mux = 8'(done_l) << FLG_L | 8'(done_r) << FLG_R;
        A_STEP: rd_mux = {6'h00, s.step};
        A_VCTL: rd_mux = {4'h0, s.vctl};
        A_GL: rd_mux = s.gl;
        A_GR: rd_mux = s.gr;
        A_DRC: rd_mux = {1'b0, s.drc};
        A_RATE: rd_mux = s.rate;
        A_PCTL: rd_mux = s.pctl & PCTL_MASK;
        A_PGAIN: rd_mux = {1'b0, s.pcode};
        default: rd_mux = 8'h00;
      endcase
    end else if (i_reg_page == PG_COEF && i_reg_addr >= A_COEF0 && i_reg_addr <= A_COEF5) begin
      rd_mux = i_reg_addr[0] ? s.coef[ci][7:0] : s.coef[ci][15:8];
    end
  end

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    n = s;
    // Host writes to the control page.
    if (i_reg_wr && i_reg_page == PG_MAIN) begin
      case (i_reg_addr)
        A_STEP: n.step = i_reg_wdata[1:0];
        A_VCTL: n.vctl = i_reg_wdata[3:0];
        A_GL: n.gl = i_reg_wdata;
        A_GR: n.gr = i_reg_wdata;
        A_DRC: n.drc = i_reg_wdata[6:0];
        A_RATE: n.rate = i_reg_wdata;
        A_PCTL: n.pctl = i_reg_wdata & PCTL_MASK;
        default: n.step = s.step;
      endcase
    end
    // Even offset holds the high byte of each coefficient.
    if (i_reg_wr && i_reg_page == PG_COEF && i_reg_addr >= A_COEF0 &&
        i_reg_addr <= A_COEF5) begin
      if (i_reg_addr[0]) begin
        n.coef[ci][7:0] = i_reg_wdata;
      end else begin
        n.coef[ci][15:8] = i_reg_wdata;
      end
    end
    // A new conversion other than code 127 wins over a host gain write in the same cycle.
    if (pot_en && i_pot_valid) begin
      n.pcode = i_pot_code;
      if (i_pot_code != POT_MUTE) begin
        n.gl = pot_map(i_pot_code);
        n.gr = pot_map(i_pot_code);
      end
    end
    // Soft-stepping toward the targets.
    if (i_smp_valid && s.step == STEP_SLOW) begin
      n.half = ~s.half;
    end else if (s.step != STEP_SLOW) begin
      n.half = 1'b0;
    end
    if (s.step == STEP_OFF || s.step == STEP_OFF2) begin
      n.appl_l = tgt_l;
      n.appl_r = tgt_r;
    end else if (step_go) begin
      if (!done_l) begin
        n.appl_l = (s.appl_l < tgt_l) ? s.appl_l + 10'sd1 : s.appl_l - 10'sd1;
      end
      if (!done_r) begin
        n.appl_r = (s.appl_r < tgt_r) ? s.appl_r + 10'sd1 : s.appl_r - 10'sd1;
      end
    end
    // Volume stage output, one cycle after the sample.
    n.vvalid = i_smp_valid;
    if (i_smp_valid) begin
      n.vol_l = apply_gain(i_smp_l, eff_l);
      n.vol_r = apply_gain(i_smp_r, eff_r);
    end
    if (lp_valid) begin
      n.energy = (lp_y == 16'sh8000) ? 16'h7fff :
                 (lp_y[15] ? 16'(-lp_y) : 16'(lp_y));
    end
    // Compressor gain, updated once per output sample.
    if (s.drc[DRC_EN_L:DRC_EN_R] == 2'b00) begin
      n.dst = DRC_IDLE;
      n.atten = 26'd0;
    end else if (s.vvalid) begin
      case (s.dst)
        DRC_IDLE: begin
          if (above) begin
            n.dst = DRC_ATTACK;
          end
        end
        DRC_ATTACK: begin
          // Cut is capped so the gain cannot drop without bound.
          if (s.atten + (ATK_BASE >> s.rate[7:4]) > ATTEN_MAX) begin
            n.atten = ATTEN_MAX;
          end else begin
            n.atten = s.atten + (ATK_BASE >> s.rate[7:4]);
          end
          if (below) begin
            n.dst = DRC_DECAY;
          end
        end
        DRC_DECAY: begin
          if (above) begin
            n.dst = DRC_ATTACK;
          end else if (s.atten <= (DCY_BASE >> s.rate[3:0])) begin
            n.atten = 26'd0;
            n.dst = DRC_IDLE;
          end else begin
            n.atten = s.atten - (DCY_BASE >> s.rate[3:0]);
          end
        end
        default: n.dst = DRC_IDLE;
      endcase
    end
    if (i_reg_rd) begin
      n.rdata = rd_mux;
    end
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s <= '{coef: COEF_RST, drc: DRC_RST, dst: DRC_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end

  assign o_reg_rdata = s.rdata;
  assign o_vol_valid = s.vvalid;
  assign o_vol_l = s.vol_l;
  assign o_vol_r = s.vol_r;
  assign o_hpf_valid = hp_valid;
  assign o_hpf = hp_y;
  assign o_energy = s.energy;
  assign o_pot_clk_sel = s.pctl[PC_CLK];
  assign o_pot_rate = s.pctl[2:0];
  assign o_drc_active = (s.dst != DRC_IDLE);

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n_s);

  property p_step_one;
    step_go && !done_l && s.step == STEP_NORM |=>
      (s.appl_l - $past(s.appl_l) == 10'sd1) || ($past(s.appl_l) - s.appl_l == 10'sd1);
  endproperty
  a_step_one: assert property (p_step_one) else $error("left step not 0.125 dB");
  property p_no_strobe;
    !i_smp_valid && s.step != STEP_OFF && s.step != STEP_OFF2 |=> $stable(s.appl_r);
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("gain moved without sample");
  property p_off;
    s.step == STEP_OFF && !i_reg_wr && !i_pot_valid ##1 1'b1 |-> s.appl_l == tgt_l;
  endproperty
  a_off: assert property (p_off) else $error("disabled stepping not immediate");
  property p_slow;
    i_smp_valid && s.step == STEP_SLOW && !s.half |=> $stable(s.appl_l);
  endproperty
  a_slow: assert property (p_slow) else $error("slow mode stepped early");
  property p_pot_off;
    !pot_en && !i_reg_wr |=> $stable(s.gl) && $stable(s.pcode);
  endproperty
  a_pot_off: assert property (p_pot_off) else $error("pot used while disabled");
  property p_pot_map;
    pot_en && i_pot_valid && i_pot_code == 7'h00 |=> s.gl == 8'h24 && s.pcode == 7'h00;
  endproperty
  a_pot_map: assert property (p_pot_map) else $error("pot code 0 not 18 dB");
  property p_pot_low;
    pot_en && i_pot_valid && i_pot_code == 7'h7e |=> s.gr == 8'h82;
  endproperty
  a_pot_low: assert property (p_pot_low) else $error("pot code 126 not -63 dB");
  property p_flag;
    i_reg_rd && i_reg_page == PG_MAIN && i_reg_addr == A_FLAG |=>
      o_reg_rdata == {3'h0, $past(done_l), 3'h0, $past(done_r)};
  endproperty
  a_flag: assert property (p_flag) else $error("completion flag read wrong");
  property p_mute;
    i_smp_valid && eff_l < EFF_FLOOR |=> o_vol_valid && o_vol_l == 16'sh0000;
  endproperty
  a_mute: assert property (p_mute) else $error("muted sample not zero");
  property p_drc_off;
    s.drc[DRC_EN_L:DRC_EN_R] == 2'b00 |=> s.atten == 26'd0 && !o_drc_active;
  endproperty
  a_drc_off: assert property (p_drc_off) else $error("cut while compression off");

  c_ramp: cover property (step_go && !done_l ##1 !done_l ##1 done_l);
  c_pot: cover property (pot_en && i_pot_valid ##1 o_step_busy);
  c_attack: cover property (s.dst == DRC_ATTACK ##[1:200] s.dst == DRC_DECAY);
endmodule
`default_nettype wire

// File: verif/dvsd_pot_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Potentiometer converter stand-in
// ----------------------------------------
module dvsd_pot_model (
  // Clock and conversion request
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [6:0] i_code,
  // Conversion result
  output logic o_valid,
  output logic [6:0] o_code
);
  // One strobe per result; between results the bus shows the inverse of
  // the last code, so that a design reading it off-strobe is caught.
  always @(posedge i_mclk) begin
    o_valid <= i_go;
    o_code <= i_go ? i_code : ~i_code;
  end
endmodule
`default_nettype wire

// File: verif/dac_volume_softstep_drc_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dac_volume_softstep_drc_bench;
  import dvsd_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, wr = 0, rd = 0, sv = 0, pgo = 0, pv;
  logic [7:0] pg = 8'h00, wd = 8'h00, rdat;
  logic [6:0] ad = 7'h00, pin = 7'h00, pc;
  logic signed [15:0] sl = 16'sh0000, sr = 16'sh0000, vl, vr;
  logic csel;
  logic vvld, hv, busy, act;
  logic signed [15:0] hp;
  logic [15:0] en;
  logic [2:0] prate;
  logic [6:0] codes [5];
  int n_fail = 0, compares = 0, cyc = 0;
  // The core clock never stops, so stepping runs to completion once enough samples arrive.
  initial forever #5 i_mclk = ~i_mclk;
  dvsd_pot_model dvsd_pot_model_inst (.i_mclk(i_mclk), .i_go(pgo), .i_code(pin),
    .o_valid(pv), .o_code(pc));
  dvsd_top dvsd_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_page(pg), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .i_smp_valid(sv), .i_smp_l(sl), .i_smp_r(sr), .o_vol_valid(vvld), .o_vol_l(vl),
    .o_vol_r(vr), .o_hpf_valid(hv), .o_hpf(hp), .o_energy(en), .i_pot_valid(pv),
    .i_pot_code(pc), .o_pot_clk_sel(csel), .o_pot_rate(prate), .o_step_busy(busy),
    .o_drc_active(act));
  // Compare one value and count it.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] p, input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    wr <= 1'b1;
    pg <= p;
    ad <= a;
    wd <= d;
    @(posedge i_mclk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data is registered at the taking edge and looked at just after it.
  task rreg(input logic [7:0] p, input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    rd <= 1'b1;
    pg <= p;
    ad <= a;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdat}, {8'h00, exp});
  endtask
  task smp(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      sv <= 1'b1;
      sl <= 16'($urandom);
      sr <= 16'($urandom);
      @(posedge i_mclk);
      sv <= 1'b0;
    end
    #1;
  endtask
  task pot(input logic [6:0] c);
    @(posedge i_mclk);
    pgo <= 1'b1;
    pin <= c;
    @(posedge i_mclk);
    pgo <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask
  // Pot code to target register value in half-dB units.
  function automatic logic [7:0] pmap(input logic [6:0] c);
    return (c <= 7'd90) ? 8'd36 - {1'b0, c} : 8'd126 - {c, 1'b0};
  endfunction
  // Estimator outputs with halving taps: the channel sum shifted, magnitude if asked.
  function automatic logic [15:0] filt(input logic signed [15:0] a, input logic signed [15:0] b,
                                       input int k, input logic mag);
    logic signed [16:0] m;
    m = (17'(a) + 17'(b)) >>> k;
    return 16'((mag && m < 0) ? -m : m);
  endfunction
  // One near full-scale sample on both channels, then let the estimator settle.
  task sbig;
    @(posedge i_mclk);
    sv <= 1'b1;
    sl <= 16'sh7000;
    sr <= 16'sh7000;
    @(posedge i_mclk);
    sv <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  task close_out;
    $display("checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    void'($urandom(32'hbade));
    codes = '{7'h00, 7'd90, 7'd91, 7'd126, 7'($urandom_range(126, 0))};
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rreg(PG_MAIN, A_DRC, 8'h0f);
    rreg(PG_MAIN, A_FLAG, 8'h11);
    rreg(PG_COEF, A_COEF0, 8'h7f);
    rreg(PG_COEF, A_COEF5, 8'hde);
    rreg(PG_MAIN, 7'h01, 8'h00);
    wreg(PG_MAIN, A_GL, 8'h02);
    chk({15'h0000, busy}, 16'h0001);
    rreg(PG_MAIN, A_FLAG, 8'h01);
    repeat (20) @(posedge i_mclk);
    rreg(PG_MAIN, A_FLAG, 8'h01);
    smp(7);
    rreg(PG_MAIN, A_FLAG, 8'h01);
    smp(1);
    rreg(PG_MAIN, A_FLAG, 8'h11);
    chk({15'h0000, busy}, 16'h0000);
    wreg(PG_MAIN, A_STEP, 8'h01);
    wreg(PG_MAIN, A_GL, 8'h00);
    smp(14);
    rreg(PG_MAIN, A_FLAG, 8'h01);
    smp(3);
    rreg(PG_MAIN, A_FLAG, 8'h11);
    wreg(PG_MAIN, A_STEP, 8'h02);
    wreg(PG_MAIN, A_VCTL, 8'h08);
    smp(1);
    chk(vl, 16'h0000);
    chk(vr, sr);
    wreg(PG_MAIN, A_VCTL, 8'h01);
    wreg(PG_MAIN, A_GR, 8'hd0);
    rreg(PG_MAIN, A_GR, 8'hd0);
    smp(1);
    chk(vr, sr);
    wreg(PG_MAIN, A_VCTL, 8'h00);
    pot(codes[4]);
    rreg(PG_MAIN, A_PGAIN, 8'h00);
    rreg(PG_MAIN, A_GL, 8'h00);
    wreg(PG_MAIN, A_PCTL, 8'hfd);
    chk({15'h0000, csel}, 16'h0001);
    chk({13'h0000, prate}, 16'h0005);
    rreg(PG_MAIN, A_PCTL, 8'hc5);
    for (int i = 0; i < 5; i++) begin
      pot(codes[i]);
      rreg(PG_MAIN, A_PGAIN, {1'b0, codes[i]});
      rreg(PG_MAIN, A_GL, pmap(codes[i]));
      rreg(PG_MAIN, A_GR, pmap(codes[i]));
    end
    // Code 127 mutes both channels and leaves the gain registers alone.
    pot(7'd127);
    rreg(PG_MAIN, A_PGAIN, 8'h7f);
    rreg(PG_MAIN, A_GL, pmap(codes[4]));
    smp(1);
    chk(vl, 16'h0000);
    // Back to register control, the right register governing both at 0 dB.
    wreg(PG_MAIN, A_PCTL, 8'h00);
    wreg(PG_MAIN, A_GR, 8'h00);
    wreg(PG_MAIN, A_GL, 8'hd0);
    wreg(PG_MAIN, A_VCTL, 8'h02);
    smp(1);
    chk(vl, sl);
    chk(vr, sr);
    // Halving taps make both sections memoryless, so their outputs are exact.
    for (int i = 0; i < 12; i++) begin
      wreg(PG_COEF, 7'(14 + i), (i % 6 == 0) ? 8'h40 : 8'h00);
    end
    rreg(PG_COEF, 7'h14, 8'h40);
    smp(1);
    chk({15'h0000, vvld}, 16'h0001);
    @(posedge i_mclk);
    #1;
    chk({15'h0000, hv}, 16'h0001);
    chk(hp, filt(sl, sr, 2, 1'b0));
    repeat (2) @(posedge i_mclk);
    #1;
    chk(en, filt(sl, sr, 3, 1'b1));
    // Threshold -24 dBFS with no hysteresis: loud samples must start a cut.
    wreg(PG_MAIN, A_DRC, 8'h7c);
    chk({15'h0000, act}, 16'h0000);
    sbig;
    chk(en, filt(16'sh7000, 16'sh7000, 3, 1'b1));
    repeat (3) sbig;
    chk({15'h0000, act}, 16'h0001);
    chk({15'h0000, vl < 16'sh7000}, 16'h0001);
    wreg(PG_MAIN, A_DRC, 8'h0f);
    @(posedge i_mclk);
    #1;
    chk({15'h0000, act}, 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
